// file: hw/iss_consts.vh
`ifndef ISS_CONSTS_VH
`define ISS_CONSTS_VH

// Register byte offsets
`define ISS_OFS_CTRL 5'h00
`define ISS_OFS_SHADOW 5'h04
`define ISS_OFS_STAT 5'h08
`define ISS_OFS_RELOAD 5'h0c
`define ISS_OFS_EVT 5'h10
`define ISS_OFS_MASK 5'h14

// irq_control fields
`define ISS_CTRL_POL_LSB 0
`define ISS_CTRL_POL_MSB 2
`define ISS_CTRL_THR_LSB 8
`define ISS_CTRL_THR_MSB 10
`define ISS_CTRL_MULTIVECTOR_MODE_BIT 12
`define ISS_CTRL_WMASK 32'h0000_1707

// priority_shadow_select fields
`define ISS_SHD_SS0_BIT 0
`define ISS_SHD_SEL_LSB 4
`define ISS_SHD_WMASK 32'hffff_fff1
`define ISS_SHD_CODE_SET0 4'h0
`define ISS_SHD_CODE_SET1 4'h1

// irq_service_status fields
`define ISS_STAT_NUM_LSB 0
`define ISS_STAT_NUM_MSB 7
`define ISS_STAT_LVL_LSB 8
`define ISS_STAT_LVL_MSB 10

// Event status / mask bits
`define ISS_EVT_WIDTH 4
`define ISS_EVT_TMR_BIT 3
`define ISS_EVT_WMASK 32'h0000_000f

// Reset values
`define ISS_RST_CTRL 32'h0000_0000
`define ISS_RST_SHADOW 32'h0000_0000
`define ISS_RST_RELOAD 32'h0000_0000
`define ISS_RST_LVL 3'h0
`define ISS_RST_NUM 8'h00
`define ISS_THR_OFF 3'h0

`endif

// file: hw/iss_edge_det.v
module iss_edge_det (
    clk_sys,
    rst_n,
    pin_in,
    polarity,
    edge_evt
);
input wire clk_sys;
input wire rst_n;
input wire [2:0] pin_in;
input wire [2:0] polarity;
output wire [2:0] edge_evt;

reg [2:0] sync0_r;
reg [2:0] sync1_r;
reg [2:0] prev_r;
reg [2:0] evt_r;

assign edge_evt = evt_r;

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
        always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                sync0_r[gi] <= 1'b0;
                sync1_r[gi] <= 1'b0;
                prev_r[gi] <= 1'b0;
                evt_r[gi] <= 1'b0;
            end else begin
                sync0_r[gi] <= pin_in[gi];
                sync1_r[gi] <= sync0_r[gi];
                prev_r[gi] <= sync1_r[gi];
                // Rising when set, falling when clear
                evt_r[gi] <= polarity[gi] ?
                    (sync1_r[gi] & ~prev_r[gi]) :
                    (~sync1_r[gi] & prev_r[gi]);
            end
        end
    end
endgenerate

endmodule // iss_edge_det

// file: hw/iss_prox_timer.v
`include "iss_consts.vh"

module iss_prox_timer (
    clk_sys,
    rst_n,
    reload,
    threshold,
    req_valid,
    req_level,
    block_req,
    expired
);
input wire clk_sys;
input wire rst_n;
input wire [31:0] reload;
input wire [2:0] threshold;
input wire req_valid;
input wire [2:0] req_level;
output wire block_req;
output wire expired;

localparam ST_IDLE = 2'b01;
localparam ST_COUNT = 2'b10;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [31:0] cnt_r;
reg [31:0] cnt_nxt;
reg release_r;
reg release_nxt;
reg expired_r;
reg expired_nxt;
wire qual;

// Code N covers levels N and below; zero turns the timer off
assign qual = req_valid && (threshold != `ISS_THR_OFF) &&
    (req_level != 3'h0) && (req_level <= threshold);
assign block_req = qual && state_r[1];
assign expired = expired_r;

always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    release_nxt = release_r & req_valid;
    expired_nxt = 1'b0;
    case (state_r)
        ST_IDLE: begin
            // Released request must not retrigger itself
            if (qual && !release_r && reload != 32'h0000_0000) begin
                cnt_nxt = reload;
                state_nxt = ST_COUNT;
            end
        end
        ST_COUNT: begin
            cnt_nxt = cnt_r - 32'h0000_0001;
            if (cnt_r == 32'h0000_0001) begin
                state_nxt = ST_IDLE;
                release_nxt = 1'b1;
                expired_nxt = 1'b1;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_IDLE;
        cnt_r <= 32'h0000_0000;
        release_r <= 1'b0;
        expired_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        release_r <= release_nxt;
        expired_r <= expired_nxt;
    end
end

endmodule // iss_prox_timer

// file: hw/iss_top.v
// Overview of operation
// - Each external input 0..2 has a polarity bit: one rising, zero falling.
// - Level seven shadow field at bits 31-28: code 0 set zero, 1 set one.
// - Levels six to one use nibbles 27-24 down to 7-4, same coding.
// - With multivector mode clear, all per-level shadow fields are ignored.
// - In single-vector mode, shadow bit 0 picks shadow set or normal set.
// - Read-only 3-bit field holds level of latest presented request; resets 0.
// - Read-only 8-bit field holds number of last serviced request; resets 0.
// - Status register bits 31-11 always read zero.
// - 32-bit read/write reload value loaded when the proximity timer triggers.
// - Threshold code N lets levels N and lower start timer; zero disables.
// - Multivector bit set selects multivectored mode, clear single-vectored.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`include "iss_consts.vh"

module iss_top (
    clk_sys,
    rst_n,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_byteenable,
    avs_readdata,
    avs_waitrequest,
    ext_irq_pin,
    ext_irq_req,
    req_valid,
    req_level,
    req_num,
    svc_ack,
    cpu_irq,
    cpu_irq_level,
    cpu_irq_num,
    cpu_shadow_set,
    cpu_multivector,
    irq
);
input wire clk_sys;
input wire rst_n;
input wire [4:0] avs_address;
input wire avs_read;
input wire avs_write;
input wire [31:0] avs_writedata;
input wire [3:0] avs_byteenable;
output wire [31:0] avs_readdata;
output wire avs_waitrequest;
input wire [2:0] ext_irq_pin;
output wire [2:0] ext_irq_req;
input wire req_valid;
input wire [2:0] req_level;
input wire [7:0] req_num;
input wire svc_ack;
output wire cpu_irq;
output wire [2:0] cpu_irq_level;
output wire [7:0] cpu_irq_num;
output wire cpu_shadow_set;
output wire cpu_multivector;
output wire irq;

////////////////////////////////////////////////////////////////////////////

// Byte-lane merge, limited to implemented bits
function [31:0] be_merge;
    input [31:0] old_val;
    input [31:0] wr_val;
    input [3:0] be;
    input [31:0] wmask;
    integer k;
    reg [31:0] lane;
    begin
        lane = 32'h0000_0000;
        for (k = 0; k < 4; k = k + 1) begin
            lane[k*8 +: 8] = {8{be[k]}};
        end
        be_merge = (old_val & ~(lane & wmask)) | (wr_val & lane & wmask);
    end
endfunction

// Reserved codes fall back to set zero
function shadow_decode;
    input [3:0] code;
    begin
        shadow_decode = (code == `ISS_SHD_CODE_SET1);
    end
endfunction

////////////////////////////////////////////////////////////////////////////

reg [31:0] ctrl_r;
reg [31:0] shadow_r;
reg [31:0] reload_r;
reg [`ISS_EVT_WIDTH-1:0] evt_r;
reg [`ISS_EVT_WIDTH-1:0] mask_r;
reg [2:0] req_lvl_r;
reg [7:0] last_num_r;
reg [31:0] rdata_r;
reg ack_r;
reg cpu_irq_r;
reg [2:0] cpu_lvl_r;
reg [7:0] cpu_num_r;
reg cpu_shd_r;
reg irq_r;

wire bus_req;
wire wr_go;
wire [2:0] polarity;
wire [2:0] threshold;
wire multivector_mode;
wire [2:0] edge_evt;
wire tmr_block;
wire tmr_expired;
wire present;
wire [`ISS_EVT_WIDTH-1:0] evt_set;
wire [`ISS_EVT_WIDTH-1:0] evt_clr;
reg [31:0] rd_mux;
reg shd_pick;

assign polarity = ctrl_r[`ISS_CTRL_POL_MSB:`ISS_CTRL_POL_LSB];
assign threshold = ctrl_r[`ISS_CTRL_THR_MSB:`ISS_CTRL_THR_LSB];
assign multivector_mode = ctrl_r[`ISS_CTRL_MULTIVECTOR_MODE_BIT];

////////////////////////////////////////////////////////////////////////////
// Avalon slave: one wait state per access

assign bus_req = avs_read | avs_write;
assign avs_waitrequest = bus_req & ~ack_r;
assign wr_go = avs_write & ack_r;
assign avs_readdata = rdata_r;

always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address & 5'h1c)
        `ISS_OFS_CTRL: rd_mux = ctrl_r & `ISS_CTRL_WMASK;
        `ISS_OFS_SHADOW: rd_mux = shadow_r & `ISS_SHD_WMASK;
        `ISS_OFS_STAT: begin
            // Upper bits stay zero
            rd_mux = {21'h00_0000, req_lvl_r, last_num_r};
        end
        `ISS_OFS_RELOAD: rd_mux = reload_r;
        `ISS_OFS_EVT: rd_mux = {28'h000_0000, evt_r};
        `ISS_OFS_MASK: rd_mux = {28'h000_0000, mask_r};
        default: rd_mux = 32'h0000_0000;
    endcase
end

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        ack_r <= 1'b0;
        rdata_r <= 32'h0000_0000;
    end else begin
        ack_r <= bus_req & ~ack_r;
        if (avs_read && !ack_r) begin
            rdata_r <= rd_mux;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Software registers

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        ctrl_r <= `ISS_RST_CTRL;
        shadow_r <= `ISS_RST_SHADOW;
        reload_r <= `ISS_RST_RELOAD;
        mask_r <= {`ISS_EVT_WIDTH{1'b0}};
    end else if (wr_go) begin
        case (avs_address & 5'h1c)
            `ISS_OFS_CTRL: begin
                ctrl_r <= be_merge(ctrl_r, avs_writedata,
                    avs_byteenable, `ISS_CTRL_WMASK);
            end
            `ISS_OFS_SHADOW: begin
                shadow_r <= be_merge(shadow_r, avs_writedata,
                    avs_byteenable, `ISS_SHD_WMASK);
            end
            `ISS_OFS_RELOAD: begin
                reload_r <= be_merge(reload_r, avs_writedata,
                    avs_byteenable, 32'hffff_ffff);
            end
            `ISS_OFS_MASK: begin
                mask_r <= avs_byteenable[0] ?
                    avs_writedata[`ISS_EVT_WIDTH-1:0] : mask_r;
            end
            default: begin
                ctrl_r <= ctrl_r;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Event status, write one to clear; a new event beats the clear

assign evt_set = {tmr_expired, edge_evt};
assign evt_clr = (wr_go && avs_byteenable[0] &&
    (avs_address & 5'h1c) == `ISS_OFS_EVT) ?
    avs_writedata[`ISS_EVT_WIDTH-1:0] : {`ISS_EVT_WIDTH{1'b0}};

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        evt_r <= {`ISS_EVT_WIDTH{1'b0}};
        irq_r <= 1'b0;
    end else begin
        evt_r <= (evt_r & ~evt_clr) | evt_set;
        irq_r <= |(((evt_r & ~evt_clr) | evt_set) & mask_r);
    end
end

assign irq = irq_r;

////////////////////////////////////////////////////////////////////////////
// External inputs and proximity timer

iss_edge_det u_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(ext_irq_pin),
    .polarity(polarity),
    .edge_evt(edge_evt)
);

assign ext_irq_req = edge_evt;

iss_prox_timer u_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reload(reload_r),
    .threshold(threshold),
    .req_valid(req_valid),
    .req_level(req_level),
    .block_req(tmr_block),
    .expired(tmr_expired)
);

////////////////////////////////////////////////////////////////////////////
// Shadow set choice for the request being presented

always @* begin
    shd_pick = 1'b0;
    if (!multivector_mode) begin
        // Per-level fields have no effect here
        shd_pick = shadow_r[`ISS_SHD_SS0_BIT];
    end else begin
        case (req_level)
            3'h7: shd_pick = shadow_decode(shadow_r[31:28]);
            3'h6: shd_pick = shadow_decode(shadow_r[27:24]);
            3'h5: shd_pick = shadow_decode(shadow_r[23:20]);
            3'h4: shd_pick = shadow_decode(shadow_r[19:16]);
            3'h3: shd_pick = shadow_decode(shadow_r[15:12]);
            3'h2: shd_pick = shadow_decode(shadow_r[11:8]);
            3'h1: shd_pick = shadow_decode(shadow_r[7:4]);
            default: shd_pick = 1'b0;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Presentation to the core and service status

assign present = req_valid & ~tmr_block;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        cpu_irq_r <= 1'b0;
        cpu_lvl_r <= `ISS_RST_LVL;
        cpu_num_r <= `ISS_RST_NUM;
        cpu_shd_r <= 1'b0;
        req_lvl_r <= `ISS_RST_LVL;
        last_num_r <= `ISS_RST_NUM;
    end else begin
        cpu_irq_r <= present;
        if (present) begin
            cpu_lvl_r <= req_level;
            cpu_num_r <= req_num;
            cpu_shd_r <= shd_pick;
            // Meaningful to software only in single-vector mode
            req_lvl_r <= req_level;
        end
        if (svc_ack && cpu_irq_r) begin
            last_num_r <= cpu_num_r;
        end
    end
end

assign cpu_irq = cpu_irq_r;
assign cpu_irq_level = cpu_lvl_r;
assign cpu_irq_num = cpu_num_r;
assign cpu_shadow_set = cpu_shd_r;
assign cpu_multivector = multivector_mode;

endmodule // iss_top

// file: verif/iss_top_props.sv
module iss_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [2:0] ext_irq_req,
    input wire req_valid,
    input wire [2:0] req_level,
    input wire [7:0] req_num,
    input wire svc_ack,
    input wire cpu_irq,
    input wire [2:0] cpu_irq_level,
    input wire [7:0] cpu_irq_num,
    input wire irq
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////
logic [7:0] num_r;
wire rd_ok = avs_read && !avs_waitrequest;
wire stat_a = avs_address[4:2] == 3'h2;
// Shadow of the serviced number
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
        num_r <= 8'h00;
    else if (svc_ack && cpu_irq)
        num_r <= cpu_irq_num;
end
////////////////////////////////////////////////////////////////////////////
wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus wait too long");
wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait with no request");
stat_zero_a: assert property (rd_ok && stat_a
    |-> avs_readdata[31:11] == 21'h0) else $error("status high bits set");
// Old value when service lands on the capture edge
num_track_a: assert property (rd_ok && stat_a && !$past(svc_ack)
    |-> avs_readdata[7:0] == num_r) else $error("serviced number wrong");
lvl_follow_a: assert property (cpu_irq |->
    cpu_irq_level == $past(req_level) && cpu_irq_num == $past(req_num))
    else $error("presented level or number wrong");
req_cause_a: assert property (cpu_irq |-> $past(req_valid))
    else $error("request presented without source");
// Per pin: other pins may pulse on the very next cycle
pulse_once_a: assert property (|ext_irq_req |=>
    (ext_irq_req & $past(ext_irq_req)) == 3'h0)
    else $error("edge request longer than one cycle");
rst_quiet_a: assert property ($rose(rst_n) |->
    !cpu_irq && !irq && ext_irq_req == 3'h0) else $error("busy after reset");
cover property (svc_ack && cpu_irq);
cover property (|ext_irq_req);
cover property ($fell(cpu_irq) && req_valid);
endmodule // iss_chk

bind iss_top iss_chk u_chk (.clk_sys, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .ext_irq_req, .req_valid,
    .req_level, .req_num, .svc_ack, .cpu_irq, .cpu_irq_level, .cpu_irq_num,
    .irq);

// file: verif/iss_core_model.sv
module iss_core_model (
    input wire clk_sys,
    input wire rst_n,
    input wire cpu_irq,
    input wire ack_en,
    input wire [3:0] ack_dly,
    output logic svc_ack
);
timeunit 1ns;
timeprecision 1ns;
logic [3:0] wait_r;
logic done_r;
// One ack per presentation, after ack_dly cycles
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        svc_ack <= 1'b0;
        wait_r <= 4'h0;
        done_r <= 1'b0;
    end else begin
        svc_ack <= 1'b0;
        if (!cpu_irq) begin
            wait_r <= 4'h0;
            done_r <= 1'b0;
        end else if (ack_en && !done_r) begin
            if (wait_r == ack_dly) begin
                svc_ack <= 1'b1;
                done_r <= 1'b1;
            end else
                wait_r <= wait_r + 4'h1;
        end
    end
end
endmodule // iss_core_model

// file: verif/tb_iss_top.sv
module tb_iss_top;
timeunit 1ns;
timeprecision 1ns;
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic [4:0] avs_address = 5'h00;
logic avs_read = 1'b0;
logic avs_write = 1'b0;
logic [31:0] avs_writedata = 32'h0000_0000;
logic [2:0] ext_irq_pin = 3'h0;
logic req_valid = 1'b0;
logic [2:0] req_level = 3'h0;
logic [7:0] req_num = 8'h00;
logic ack_en = 1'b0;
logic [3:0] ack_dly = 4'h0;
wire [31:0] avs_readdata;
wire avs_waitrequest, svc_ack, cpu_irq, cpu_shadow_set, cpu_multivector, irq;
wire [2:0] ext_irq_req, cpu_irq_level;
wire [7:0] cpu_irq_num;
int miscompares = 0;
int n_compared = 0;
int i, m, lo;
logic [31:0] v;

always #50 clk_sys = ~clk_sys;

iss_top uut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .ext_irq_pin, .ext_irq_req, .req_valid, .req_level, .req_num, .svc_ack,
    .cpu_irq, .cpu_irq_level, .cpu_irq_num, .cpu_shadow_set,
    .cpu_multivector, .irq);
iss_core_model u_core (.clk_sys, .rst_n, .cpu_irq, .ack_en, .ack_dly,
    .svc_ack);
////////////////////////////////////////////////////////////////////////////
task wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task chk(input string nm, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e) begin
        miscompares++;
        $display("[ERR] %s exp %h got %h", nm, e, g);
    end
endtask
// Gap edge first, so strobes never toggle twice in one step
task wr(input [4:0] a, input [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
endtask
task rchk(input [4:0] a, input [31:0] e);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
    chk("reg", e, v);
endtask
task pres(input [2:0] l, input [7:0] n);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_level <= l;
    req_num <= n;
    repeat (2) @(posedge clk_sys);
endtask
task svc(input [3:0] d, input [2:0] l, input [7:0] n, input [31:0] e);
    ack_dly <= d;
    pres(l, n);
    ack_en <= 1'b1;
    while (svc_ack !== 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    ack_en <= 1'b0;
    rchk(5'h08, e);
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    wrap_up;
end

initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++)
        rchk(5'(i * 4), 32'h0000_0000);
    wr(5'h00, 32'hffff_ffff);
    rchk(5'h00, 32'h0000_1707);
    chk("multivector_mode", 32'h0000_0001, cpu_multivector);
    wr(5'h04, 32'hffff_ffff);
    rchk(5'h04, 32'hffff_fff1);
    wr(5'h08, 32'hffff_ffff);
    rchk(5'h08, 32'h0000_0000);
    wr(5'h0c, 32'ha5a5_5a5a);
    rchk(5'h0c, 32'ha5a5_5a5a);
    wr(5'h18, 32'hffff_ffff);
    rchk(5'h18, 32'h0000_0000);
    $display("registers done");
    // Odd levels pick set one, even ones reserved codes; mode off ignores
    for (m = 0; m < 3; m++) begin
        wr(5'h00, m == 0 ? 32'h0000_1000 : 32'h0000_0000);
        wr(5'h04, m == 2 ? 32'h1f12_1a11 : 32'h1f12_1a10);
        for (i = 1; i < 8; i++) begin
            pres(3'(i), 8'(i));
            chk("shadow", m == 0 ? i % 2 : m - 1, cpu_shadow_set);
        end
    end
    $display("shadow done");
    svc(4'h3, 3'h5, 8'h3c, 32'h0000_053c);
    svc(4'h0, 3'h1, 8'hff, 32'h0000_01ff);
    $display("service done");
    wr(5'h00, 32'h0000_0005);
    wr(5'h14, 32'h0000_0007);
    wr(5'h10, 32'h0000_000f);
    ext_irq_pin <= 3'h7;
    repeat (6) @(posedge clk_sys);
    rchk(5'h10, 32'h0000_0005);
    chk("irq", 32'h0000_0001, irq);
    wr(5'h14, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0000_0000, irq);
    wr(5'h14, 32'h0000_0007);
    wr(5'h10, 32'h0000_0005);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0000_0000, irq);
    ext_irq_pin <= 3'h0;
    repeat (6) @(posedge clk_sys);
    rchk(5'h10, 32'h0000_0002);
    chk("irq", 32'h0000_0001, irq);
    wr(5'h10, 32'h0000_0002);
    $display("edges done");
    wr(5'h0c, 32'h0000_0005);
    wr(5'h00, 32'h0000_0300);
    pres(3'h5, 8'h01);
    lo = 0;
    repeat (8) begin
        @(posedge clk_sys);
        if (cpu_irq !== 1'b1) lo++;
    end
    chk("free", 32'h0000_0000, lo);
    req_valid <= 1'b0;
    pres(3'h3, 8'h33);
    lo = 0;
    repeat (14) begin
        @(posedge clk_sys);
        if (cpu_irq !== 1'b1) lo++;
    end
    // Held for exactly the reload count
    chk("held", 32'h0000_0005, lo);
    chk("back", 32'h0000_0001, cpu_irq);
    rchk(5'h10, 32'h0000_0008);
    $display("timer done");
    wrap_up;
end
endmodule // tb_iss_top
